// file: verilog/ctemp_pkg.sv
// Constants, types and helpers shared by the channel-to-storage bridge
package ctemp_pkg;
  // Clock and storage word pacing
  localparam int CLK_NS = 4;
  localparam int WORD_NS = 100;
  localparam int WORD_CYC = (WORD_NS + CLK_NS - 1) / CLK_NS;
  // Word and record geometry
  localparam int CW = 12;
  localparam int SW = 60;
  localparam int AW = 24;
  localparam int FLAG_BIT = 23;
  localparam logic [3:0] REC_LAST = 4'h7;
  localparam logic [2:0] SEG_LAST = 3'h4;
  localparam logic [4:0] PACE_LOAD = 5'(WORD_CYC - 1);
  // Function code fields
  localparam logic [2:0] EQ_SEL = 3'h5;
  localparam logic [5:0] FN_BREAD = 6'h01;
  localparam logic [5:0] FN_RONE = 6'h21;
  localparam logic [5:0] FN_WRITE = 6'h02;
  localparam logic [5:0] FN_STAT = 6'h04;
  localparam logic [5:0] FN_MCLR = 6'h08;
  localparam logic [2:0] MOD_ZCH = 3'h1;
  localparam logic [2:0] MOD_ZDATA = 3'h2;
  localparam logic [2:0] MOD_ZADR = 3'h4;
  // Port status bit positions
  localparam int ST_ABORT = 0;
  localparam int ST_ACCEPT = 1;
  localparam int ST_SPERR = 2;
  localparam int ST_CHERR = 4;
  localparam int ST_DPERR = 5;
  // Register offsets and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SCAN = 8'h04;
  localparam logic [3:0] REG_PADDR_HI = 4'h1;
  localparam logic [3:0] REG_PSTAT_HI = 4'h2;
  localparam logic CTRL_CHK_RST = 1'b1;
  localparam logic CTRL_SCAN_RST = 1'b1;
  // Port and transfer states
  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_ADR1 = 3'b001, P_ADR2 = 3'b010, P_WFILL = 3'b011,
    P_WREQ = 3'b100, P_RREQ = 3'b101, P_RSEND = 3'b110, P_STAT = 3'b111
  } ctemp_pst_t;
  typedef enum logic [1:0] {
    X_IDLE = 2'b00, X_ADDR = 2'b01, X_DATA = 2'b10, X_END = 2'b11
  } ctemp_xst_t;
  // Odd parity bit over a zero-extended word
  function automatic logic odd_par(input logic [SW-1:0] d);
    return ~(^d);
  endfunction
  // Twelve-bit segment of a storage word, first segment at the top
  function automatic logic [CW-1:0] seg_of(input logic [SW-1:0] w, input logic [2:0] s);
    case (s)
      3'h0: seg_of = w[59:48];
      3'h1: seg_of = w[47:36];
      3'h2: seg_of = w[35:24];
      3'h3: seg_of = w[23:12];
      default: seg_of = w[11:0];
    endcase
  endfunction
endpackage

// file: verilog/ctemp_rec_mem.sv
// Record buffer memory with registered read data
`timescale 1ns/100ps
module ctemp_rec_mem #(
  parameter int W = 60,
  parameter int D = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [$clog2(D)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [$clog2(D)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } ctemp_mem_t;
  ctemp_mem_t s, next_s;

  // Write port and read register
  always_comb begin
    next_s = s;
    if (we_i) begin
      next_s.mem[waddr_i] = wdata_i;
    end
    next_s.rd = s.mem[raddr_i];
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rd;
endmodule

// file: verilog/ctemp_scanner.sv
// Cyclic scanner that grants the storage path to one port at a time
`timescale 1ns/100ps
module ctemp_scanner #(
  parameter int NP = 4,
  parameter int PW = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [NP-1:0] req_i,
  output logic gnt_v_o,
  output logic [PW-1:0] gnt_idx_o
);
  typedef struct packed {
    logic [PW-1:0] ptr;
  } ctemp_scan_t;
  ctemp_scan_t s, next_s;

  always_comb begin
    next_s = s;
    if (en_i) begin
      next_s.ptr = (s.ptr == PW'(NP - 1)) ? '0 : s.ptr + PW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign gnt_v_o = en_i & req_i[s.ptr];
  assign gnt_idx_o = s.ptr;
endmodule

// file: verilog/ctemp_top.sv
// Multi-port bridge from processor channels to one storage controller access
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ctemp_top import ctemp_pkg::*; #(
  parameter int NP = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NP-1:0] ch_func_i,
  input wire logic [NP-1:0] ch_full_i,
  input wire logic [NP-1:0] ch_empty_i,
  input wire logic [NP-1:0] ch_disc_i,
  input wire logic [NP-1:0][CW-1:0] ch_data_i,
  input wire logic [NP-1:0] ch_par_i,
  output logic [NP-1:0] ch_inact_o,
  output logic [NP-1:0] ch_full_o,
  output logic [NP-1:0] ch_empty_o,
  output logic [NP-1:0][CW-1:0] ch_data_o,
  output logic [NP-1:0] ch_par_o,
  output logic xs_req_o,
  output logic xs_write_o,
  output logic [AW-1:0] xs_addr_o,
  output logic xs_addr_par_o,
  output logic xs_zpar_cmd_o,
  input wire logic xs_accept_i,
  input wire logic xs_abort_i,
  input wire logic xs_perr_i,
  input wire logic xs_rd_go_i,
  input wire logic [SW-1:0] xs_rd_data_i,
  input wire logic xs_rd_par_i,
  output logic xs_wr_go_o,
  output logic [SW-1:0] xs_wr_data_o,
  output logic xs_wr_par_o
);
  localparam int PW = (NP > 1) ? $clog2(NP) : 1;

  typedef struct packed {
    ctemp_pst_t [NP-1:0] st;
    logic [NP-1:0][AW-1:0] addr;
    logic [NP-1:0][2:0] md;
    logic [NP-1:0] wr;
    logic [NP-1:0] one;
    logic [NP-1:0] flag;
    logic [NP-1:0] last;
    logic [NP-1:0][2:0] seg;
    logic [NP-1:0][3:0] widx;
    logic [NP-1:0][1:0] ph;
    logic [NP-1:0][SW-1:0] asm_w;
    logic [NP-1:0][5:0] stat;
    logic [NP-1:0] ch_full;
    logic [NP-1:0] ch_empty;
    logic [NP-1:0] ch_inact;
    logic [NP-1:0][CW-1:0] ch_data;
    logic [NP-1:0] ch_par;
    ctemp_xst_t xst;
    logic [PW-1:0] xport;
    logic [3:0] xcnt;
    logic [4:0] pace;
    logic xs_req;
    logic xs_write;
    logic [AW-1:0] xs_addr;
    logic xs_addr_par;
    logic xs_zcmd;
    logic xs_wr_go;
    logic [SW-1:0] xs_wr_data;
    logic xs_wr_par;
    logic chk_en;
    logic scan_en;
    logic [31:0] prdata;
    logic perr_b;
  } ctemp_state_t;

  ctemp_state_t s, next_s;
  logic [NP-1:0] mem_we;
  logic [NP-1:0][2:0] mem_wa;
  logic [NP-1:0][SW-1:0] mem_wd;
  logic [NP-1:0][2:0] mem_ra;
  logic [NP-1:0][SW-1:0] mem_rd;
  logic [NP-1:0] port_req;
  logic gnt_v;
  logic [PW-1:0] gnt_idx;

  // Status word as seen by the processor
  function automatic logic [CW-1:0] stat_word(input logic [5:0] st, input logic wbusy);
    return {6'h00, st[ST_DPERR], st[ST_CHERR], wbusy, st[2:0]};
  endfunction

  for (genvar g = 0; g < NP; g++) begin : g_mem
    ctemp_rec_mem #(.W(SW), .D(8)) u_mem (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .we_i(mem_we[g]),
      .waddr_i(mem_wa[g]),
      .wdata_i(mem_wd[g]),
      .raddr_i(mem_ra[g]),
      .rdata_o(mem_rd[g])
    );
    assign port_req[g] = (s.st[g] == P_WREQ) || (s.st[g] == P_RREQ);
  end

  // scanner runs only while the storage path is free
  ctemp_scanner #(.NP(NP), .PW(PW)) u_scan (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(s.scan_en && (s.xst == X_IDLE)),
    .req_i(port_req),
    .gnt_v_o(gnt_v),
    .gnt_idx_o(gnt_idx)
  );

  // Port sequencing, storage transfer and register access
  always_comb begin
    logic sel;
    logic pok;
    logic [5:0] fn;
    logic [2:0] md;
    logic [CW-1:0] d;
    int p;
    sel = 1'b0;
    pok = 1'b0;
    fn = '0;
    md = '0;
    d = '0;
    p = 0;
    next_s = s;
    mem_we = '0;
    mem_wa = '0;
    mem_wd = '0;
    mem_ra = '0;
    next_s.ch_inact = '0;
    next_s.ch_empty = '0;
    next_s.xs_wr_go = 1'b0;
    for (int i = 0; i < NP; i++) begin
      d = ch_data_i[i];
      pok = !s.chk_en || (^{d, ch_par_i[i]});
      sel = (s.xst != X_IDLE) && (s.xport == PW'(i));
      mem_ra[i] = (s.st[i] == P_WREQ) ? s.xcnt[2:0] : s.widx[i][2:0];
      if (ch_func_i[i] && !sel) begin
        fn = d[5:0];
        md = d[8:6];
        if (d[11:9] == EQ_SEL && pok) begin
          next_s.ch_inact[i] = 1'b1;
          next_s.ch_full[i] = 1'b0;
          if (fn != FN_STAT) begin
            next_s.stat[i] = '0;
          end
          case (fn)
            FN_BREAD, FN_RONE: begin
              next_s.st[i] = P_ADR1;
              next_s.wr[i] = 1'b0;
              next_s.one[i] = (fn == FN_RONE);
              next_s.md[i] = md;
            end
            FN_WRITE: begin
              next_s.st[i] = P_ADR1;
              next_s.wr[i] = 1'b1;
              next_s.one[i] = 1'b0;
              next_s.md[i] = md;
            end
            FN_STAT: begin
              next_s.st[i] = P_STAT;
              next_s.ph[i] = 2'h0;
              next_s.md[i] = md;
            end
            FN_MCLR: begin
              next_s.st[i] = P_IDLE;
              next_s.md[i] = '0;
              next_s.widx[i] = '0;
              next_s.seg[i] = '0;
            end
            default: begin
              next_s.st[i] = s.st[i];
            end
          endcase
        end
      end else begin
        case (s.st[i])
          P_ADR1: if (ch_full_i[i]) begin
            // first word to upper half empty reply
            next_s.addr[i][23:12] = d;
            next_s.ch_empty[i] = 1'b1;
            next_s.stat[i][ST_CHERR] = s.stat[i][ST_CHERR] | !pok;
            next_s.st[i] = P_ADR2;
          end
          P_ADR2: if (ch_full_i[i]) begin
            // second word to lower half empty reply
            next_s.addr[i][11:0] = d;
            next_s.ch_empty[i] = 1'b1;
            next_s.stat[i][ST_CHERR] = s.stat[i][ST_CHERR] | !pok;
            // bit 23 on block read marks flag operation
            next_s.flag[i] = !s.wr[i] && !s.one[i] && s.addr[i][FLAG_BIT];
            next_s.widx[i] = '0;
            next_s.seg[i] = '0;
            next_s.last[i] = 1'b0;
            next_s.st[i] = s.wr[i] ? P_WFILL : P_RREQ;
          end
          P_WFILL: if (ch_full_i[i]) begin
            // assemble five segments into one word
            next_s.asm_w[i] = {s.asm_w[i][SW-CW-1:0], d};
            next_s.ch_empty[i] = 1'b1;
            next_s.stat[i][ST_CHERR] = s.stat[i][ST_CHERR] | !pok;
            if (s.seg[i] == SEG_LAST) begin
              mem_we[i] = 1'b1;
              mem_wa[i] = s.widx[i][2:0];
              mem_wd[i] = {s.asm_w[i][SW-CW-1:0], d};
              next_s.seg[i] = '0;
              next_s.widx[i] = s.widx[i] + 4'h1;
              if (s.widx[i] == REC_LAST) begin
                next_s.st[i] = P_WREQ;
              end
            end else begin
              next_s.seg[i] = s.seg[i] + 3'h1;
            end
          end else if (ch_disc_i[i]) begin
            next_s.last[i] = 1'b1;
            next_s.seg[i] = '0;
            next_s.st[i] = (s.widx[i] != 4'h0) ? P_WREQ : P_IDLE;
          end
          P_RREQ: if (ch_disc_i[i] && !sel) begin
            next_s.st[i] = P_IDLE;
          end
          P_RSEND: begin
            if (ch_disc_i[i]) begin
              next_s.ch_full[i] = 1'b0;
              next_s.st[i] = P_IDLE;
            end else if (s.ph[i] == 2'h0) begin
              // split word into channel segments X=1 zero parity
              next_s.ch_data[i] = seg_of(mem_rd[i], s.seg[i]);
              next_s.ch_par[i] = (s.md[i] == MOD_ZCH) ? 1'b0 :
                odd_par(SW'(seg_of(mem_rd[i], s.seg[i])));
              next_s.ch_full[i] = 1'b1;
              next_s.ph[i] = 2'h1;
            end else if (s.ph[i] == 2'h1) begin
              if (ch_empty_i[i]) begin
                next_s.ch_full[i] = 1'b0;
                next_s.ph[i] = 2'h2;
                if (s.seg[i] == SEG_LAST) begin
                  next_s.seg[i] = '0;
                  next_s.widx[i] = s.widx[i] + 4'h1;
                  // further records re-queue behind the scan
                  if (s.widx[i] == REC_LAST) begin
                    next_s.st[i] = s.one[i] ? P_IDLE : P_RREQ;
                  end
                end else begin
                  next_s.seg[i] = s.seg[i] + 3'h1;
                end
              end
            end else begin
              next_s.ph[i] = 2'h0;
            end
          end
          P_STAT: begin
            if (s.ph[i] == 2'h0) begin
              next_s.ch_data[i] = stat_word(s.stat[i], 1'b0);
              next_s.ch_par[i] = (s.md[i] == MOD_ZCH) ? 1'b0 :
                odd_par(SW'(stat_word(s.stat[i], 1'b0)));
              next_s.ch_full[i] = 1'b1;
              next_s.ph[i] = 2'h1;
            end else if (ch_empty_i[i] || ch_disc_i[i]) begin
              next_s.ch_full[i] = 1'b0;
              next_s.st[i] = P_IDLE;
            end
          end
          default: begin
            next_s.st[i] = s.st[i];
          end
        endcase
      end
    end

    // Storage path transfer sequencer
    p = int'(s.xport);
    if (s.xst != X_IDLE && xs_perr_i) begin
      next_s.stat[p][ST_SPERR] = 1'b1;
    end
    case (s.xst)
      X_IDLE: if (gnt_v) begin
        p = int'(gnt_idx);
        next_s.xport = gnt_idx;
        next_s.xst = X_ADDR;
        next_s.xcnt = '0;
        next_s.pace = '0;
        next_s.xs_req = 1'b1;
        next_s.xs_write = (s.st[p] == P_WREQ);
        next_s.xs_addr = s.addr[p];
        // X or Y=4 zero address parity
        next_s.xs_addr_par = (s.md[p] == MOD_ZADR) ? 1'b0 : odd_par(SW'(s.addr[p]));
        // X=2 asks controller for zero data parity
        next_s.xs_zcmd = (s.st[p] == P_RREQ) && (s.md[p] == MOD_ZDATA);
        next_s.stat[p][ST_ACCEPT] = 1'b0;
      end
      X_ADDR: begin
        if (xs_abort_i) begin
          next_s.xs_req = 1'b0;
          next_s.stat[p][ST_ABORT] = 1'b1;
          next_s.xst = X_END;
        end else if (xs_accept_i) begin
          next_s.xs_req = 1'b0;
          next_s.stat[p][ST_ACCEPT] = 1'b1;
          next_s.xst = (s.flag[p] && !s.xs_write) ? X_END : X_DATA;
        end
      end
      X_DATA: begin
        if (xs_abort_i) begin
          next_s.stat[p][ST_ABORT] = 1'b1;
          next_s.xst = X_END;
        end else if (s.xs_write) begin
          // paced storage writes eight words per grant
          if (s.pace == 5'h00) begin
            next_s.xs_wr_go = 1'b1;
            next_s.xs_wr_data = (s.xcnt < s.widx[p]) ? mem_rd[p] : '0;
            // data parity Y=2 zero data parity
            next_s.xs_wr_par = (s.md[p] == MOD_ZDATA) ? 1'b0 :
              odd_par((s.xcnt < s.widx[p]) ? mem_rd[p] : '0);
            next_s.pace = PACE_LOAD;
            next_s.xcnt = s.xcnt + 4'h1;
            next_s.addr[p] = s.addr[p] + AW'(1);
            if (s.xcnt == REC_LAST) begin
              next_s.xst = X_END;
            end
          end else begin
            next_s.pace = s.pace - 5'h01;
          end
        end else if (xs_rd_go_i) begin
          mem_we[p] = 1'b1;
          mem_wa[p] = s.xcnt[2:0];
          mem_wd[p] = xs_rd_data_i;
          if (!s.xs_zcmd && !(^{xs_rd_data_i, xs_rd_par_i})) begin
            next_s.stat[p][ST_DPERR] = 1'b1;
          end
          next_s.addr[p] = s.addr[p] + AW'(1);
          next_s.xs_addr = s.addr[p] + AW'(1);
          next_s.xcnt = s.xcnt + 4'h1;
          if (s.xcnt == REC_LAST) begin
            next_s.xst = X_END;
          end
        end
      end
      default: begin
        next_s.xst = X_IDLE;
        next_s.widx[p] = '0;
        next_s.seg[p] = '0;
        next_s.ph[p] = 2'h0;
        if (s.xs_write) begin
          next_s.st[p] = (s.last[p] || s.stat[p][ST_ABORT]) ? P_IDLE : P_WFILL;
          next_s.last[p] = 1'b0;
        end else begin
          next_s.st[p] = (s.flag[p] || s.stat[p][ST_ABORT]) ? P_IDLE : P_RSEND;
        end
      end
    endcase

    // Register bus: decode in setup, act in access
    if (psel_i && !penable_i) begin
      next_s.prdata = '0;
      next_s.perr_b = 1'b0;
      if (paddr_i == REG_CTRL) begin
        next_s.prdata = {30'h0, s.scan_en, s.chk_en};
      end else if (paddr_i == REG_SCAN) begin
        next_s.prdata = {24'h0, s.xst, 2'(s.xport), s.xcnt};
      end else if (paddr_i[7:4] == REG_PADDR_HI && int'(paddr_i[3:2]) < NP) begin
        next_s.prdata = {5'h00, s.st[paddr_i[3:2]], s.addr[paddr_i[3:2]]};
      end else if (paddr_i[7:4] == REG_PSTAT_HI && int'(paddr_i[3:2]) < NP) begin
        next_s.prdata = {20'h0, stat_word(s.stat[paddr_i[3:2]],
          s.st[paddr_i[3:2]] == P_WFILL || s.st[paddr_i[3:2]] == P_WREQ)};
      end else begin
        next_s.perr_b = 1'b1;
      end
    end
    if (psel_i && penable_i && pwrite_i && !s.perr_b && paddr_i == REG_CTRL) begin
      next_s.chk_en = pwdata_i[0];
      next_s.scan_en = pwdata_i[1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.chk_en <= CTRL_CHK_RST;
      s.scan_en <= CTRL_SCAN_RST;
    end else begin
      s <= next_s;
    end
  end

  // Output drive
  assign prdata_o = (psel_i && penable_i) ? s.prdata : '0;
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & s.perr_b;
  assign ch_inact_o = s.ch_inact;
  assign ch_full_o = s.ch_full;
  assign ch_empty_o = s.ch_empty;
  assign ch_data_o = s.ch_data;
  assign ch_par_o = s.ch_par;
  assign xs_req_o = s.xs_req;
  assign xs_write_o = s.xs_write;
  assign xs_addr_o = s.xs_addr;
  assign xs_addr_par_o = s.xs_addr_par;
  assign xs_zpar_cmd_o = s.xs_zcmd;
  assign xs_wr_go_o = s.xs_wr_go;
  assign xs_wr_data_o = s.xs_wr_data;
  assign xs_wr_par_o = s.xs_wr_par;
endmodule

// file: tb/ctemp_sva.sv
// Port checker for the channel-to-storage bridge
`timescale 1ns/100ps
module ctemp_sva import ctemp_pkg::*; #(
  parameter int NP = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [NP-1:0] ch_func_i,
  input wire logic [NP-1:0][CW-1:0] ch_data_i,
  input wire logic [NP-1:0] ch_inact_o,
  input wire logic xs_req_o,
  input wire logic xs_write_o,
  input wire logic [AW-1:0] xs_addr_o,
  input wire logic xs_accept_i,
  input wire logic xs_abort_i,
  input wire logic xs_rd_go_i,
  input wire logic xs_wr_go_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Two storage write pulses one word time apart
  sequence s_go2;
    xs_wr_go_o ##25 xs_wr_go_o;
  endsequence
  property p_rdy;
    pready_o == (psel_i && penable_i);
  endproperty
  property p_err;
    psel_i && penable_i && paddr_i == 8'h08 |-> pslverr_o;
  endproperty
  property p_sel;
    ch_func_i[0] && ch_data_i[0][11:9] != EQ_SEL |=> !ch_inact_o[0];
  endproperty
  property p_ack;
    ch_inact_o[0] |-> $past(ch_func_i[0]) && $past(ch_data_i[0][11:9]) == EQ_SEL;
  endproperty
  property p_hold;
    xs_req_o && !xs_accept_i && !xs_abort_i |=> xs_req_o;
  endproperty
  property p_go2;
    xs_accept_i && xs_req_o && xs_write_o |-> ##2 s_go2;
  endproperty
  property p_pace;
    xs_wr_go_o |=> !xs_wr_go_o [*8];
  endproperty
  property p_inc;
    xs_rd_go_i && !xs_write_o |-> ##2 xs_addr_o == $past(xs_addr_o, 2) + 24'h1;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready wrong");
  a_err: assert property (p_err) else $error("no slave error");
  a_sel: assert property (p_sel) else $error("foreign code acknowledged");
  a_ack: assert property (p_ack) else $error("acknowledge without function");
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_go2: assert property (p_go2) else $error("write pulses misplaced");
  a_pace: assert property (p_pace) else $error("write pulses too close");
  a_inc: assert property (p_inc) else $error("address not advanced");
endmodule
bind ctemp_top ctemp_sva #(.NP(NP)) u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ch_func_i(ch_func_i), .ch_data_i(ch_data_i), .ch_inact_o(ch_inact_o), .xs_req_o(xs_req_o),
  .xs_write_o(xs_write_o), .xs_addr_o(xs_addr_o), .xs_accept_i(xs_accept_i), .xs_abort_i(xs_abort_i),
  .xs_rd_go_i(xs_rd_go_i), .xs_wr_go_o(xs_wr_go_o));

// file: tb/ctemp_xs_model.sv
// Storage controller model: accepts requests and returns read records
`timescale 1ns/100ps
module ctemp_xs_model import ctemp_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] lat_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [AW-1:0] addr_i,
  output logic accept_o,
  output logic abort_o,
  output logic perr_o,
  output logic rd_go_o,
  output logic [SW-1:0] rd_data_o,
  output logic rd_par_o
);
  logic [SW-1:0] wd;
  // No aborts or parity complaints from this model
  assign abort_o = 1'b0;
  assign perr_o = 1'b0;
  // Request service loop, latency set by the bench
  initial begin
    accept_o = 1'b0;
    rd_go_o = 1'b0;
    rd_data_o = '0;
    rd_par_o = 1'b0;
    forever begin
      @(posedge sys_clk_i);
      if (rst_n_i && req_i) begin
        repeat (lat_i) @(posedge sys_clk_i);
        accept_o <= 1'b1;
        @(posedge sys_clk_i);
        accept_o <= 1'b0;
        // eight words per read, none for a flag op
        if (!write_i && !addr_i[FLAG_BIT]) for (int k = 0; k < 8; k++) begin
          repeat (2 + lat_i) @(posedge sys_clk_i);
          wd = {12'(k), 12'(k) + 12'h100, 12'(k) + 12'h200, 12'(k) + 12'h300, 12'(k) + 12'h400};
          rd_go_o <= 1'b1;
          rd_data_o <= wd;
          rd_par_o <= ~^wd;
          @(posedge sys_clk_i);
          rd_go_o <= 1'b0;
          rd_data_o <= ~wd;
          rd_par_o <= ^wd;
        end
      end
    end
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the channel-to-storage bridge
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench import ctemp_pkg::*;;
  logic sys_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, req_d = 0;
  logic [7:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, seed = 32'h662A;
  logic pready_o, pslverr_o, xs_req_o, xs_write_o, xs_addr_par_o, xs_zpar_cmd_o, xs_accept_i, xs_abort_i;
  logic xs_perr_i, xs_rd_go_i, xs_rd_par_i, xs_wr_go_o, xs_wr_par_o;
  logic [1:0] ch_func_i = '0, ch_full_i = '0, ch_empty_i = '0, ch_disc_i = '0, ch_par_i = '0;
  logic [1:0] ch_inact_o, ch_full_o, ch_empty_o, ch_par_o;
  logic [1:0][CW-1:0] ch_data_i = '0, ch_data_o;
  logic [AW-1:0] xs_addr_o;
  logic [SW-1:0] xs_rd_data_i, xs_wr_data_o, w;
  logic [3:0] lat = 4'h0;
  logic [63:0] e;
  logic [32:0] q_apb[$];
  logic [CW-1:0] q_ch[$];
  logic [SW-1:0] q_wr[$];
  logic [AW:0] q_rq[$];
  int n_fail = 0, comparisons = 0, hold = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  ctemp_top #(.NP(2)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ch_func_i(ch_func_i), .ch_full_i(ch_full_i), .ch_empty_i(ch_empty_i),
    .ch_disc_i(ch_disc_i), .ch_data_i(ch_data_i), .ch_par_i(ch_par_i), .ch_inact_o(ch_inact_o),
    .ch_full_o(ch_full_o), .ch_empty_o(ch_empty_o), .ch_data_o(ch_data_o), .ch_par_o(ch_par_o),
    .xs_req_o(xs_req_o), .xs_write_o(xs_write_o), .xs_addr_o(xs_addr_o), .xs_addr_par_o(xs_addr_par_o),
    .xs_zpar_cmd_o(xs_zpar_cmd_o), .xs_accept_i(xs_accept_i), .xs_abort_i(xs_abort_i), .xs_perr_i(xs_perr_i),
    .xs_rd_go_i(xs_rd_go_i), .xs_rd_data_i(xs_rd_data_i), .xs_rd_par_i(xs_rd_par_i), .xs_wr_go_o(xs_wr_go_o),
    .xs_wr_data_o(xs_wr_data_o), .xs_wr_par_o(xs_wr_par_o));
  ctemp_xs_model u_xs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lat_i(lat), .req_i(xs_req_o),
    .write_i(xs_write_o), .addr_i(xs_addr_o), .accept_o(xs_accept_i), .abort_o(xs_abort_i),
    .perr_o(xs_perr_i), .rd_go_o(xs_rd_go_i), .rd_data_o(xs_rd_data_i), .rd_par_o(xs_rd_par_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    `CHK("queues", 0, q_apb.size() + q_ch.size() + q_wr.size() + q_rq.size())
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; reads note the expected {error, data}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] x);
    @(posedge sys_clk_i);
    if (!wr) q_apb.push_back(x);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= x[31:0];
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // One channel word (function or full) and its expected acknowledge
  task automatic chw(input logic f, input logic [CW-1:0] d, input logic bad, input logic x);
    logic got;
    got = 1'b0;
    @(posedge sys_clk_i);
    ch_data_i[0] <= d;
    ch_par_i[0] <= ~^d ^ bad;
    if (f) ch_func_i[0] <= 1'b1;
    else ch_full_i[0] <= 1'b1;
    @(posedge sys_clk_i);
    ch_func_i[0] <= 1'b0;
    ch_full_i[0] <= 1'b0;
    repeat (3) begin
      @(negedge sys_clk_i);
      got |= f ? ch_inact_o[0] : ch_empty_o[0];
    end
    `CHK("ack", x, got)
  endtask
  // Watcher: each result that appears is compared with the oldest note
  always @(posedge sys_clk_i) begin
    req_d <= xs_req_o;
    if (psel_i && penable_i && pready_o && !pwrite_i) begin
      e = 64'(q_apb.pop_front());
      `CHK("apb", e, 64'({pslverr_o, prdata_o}))
    end
    if (xs_req_o && !req_d) begin
      e = 64'(q_rq.pop_front());
      `CHK("req", e, 64'({xs_zpar_cmd_o, xs_addr_o}))
      `CHK("apar", ~^xs_addr_o, xs_addr_par_o)
    end
    if (xs_wr_go_o) begin
      e = 64'(q_wr.pop_front());
      `CHK("wdata", e, 64'(xs_wr_data_o))
      `CHK("wpar", ~^xs_wr_data_o, xs_wr_par_o)
    end
    if (hold > 0) begin
      hold <= hold - 1;
      ch_empty_i[0] <= 1'b0;
    end else if (ch_full_o[0] && (rnd() % 2)) begin
      e = 64'(q_ch.pop_front());
      `CHK("chdata", e, 64'(ch_data_o[0]))
      `CHK("chpar", ~^ch_data_o[0], ch_par_o[0])
      ch_empty_i[0] <= 1'b1;
      hold <= 3;
    end
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, 8'h00, 33'h3);
    apb(1'b0, 8'h08, 33'h100000000);
    $display("Register test done");
    q_rq.push_back(25'h0012345);
    chw(1'b1, {EQ_SEL, 3'h0, FN_WRITE}, 1'b0, 1'b1);
    chw(1'b0, 12'h012, 1'b0, 1'b1);
    chw(1'b0, 12'h345, 1'b0, 1'b1);
    apb(1'b0, 8'h10, 33'h03012345);
    for (int k = 0; k < 8; k++) begin
      w = SW'({rnd(), rnd()});
      q_wr.push_back(w);
      for (int s = 0; s < 5; s++) chw(1'b0, w[59 - 12 * s -: 12], 1'b0, 1'b1);
    end
    wait (q_wr.size() == 0);
    $display("Write test done");
    lat = 4'h5;
    q_rq.push_back(25'h0000100);
    for (int k = 0; k < 8; k++) for (int s = 0; s < 5; s++) q_ch.push_back(12'(k) + 12'(256 * s));
    chw(1'b1, {EQ_SEL, 3'h0, FN_RONE}, 1'b0, 1'b1);
    chw(1'b0, 12'h000, 1'b0, 1'b1);
    chw(1'b0, 12'h100, 1'b0, 1'b1);
    wait (q_ch.size() == 0);
    repeat (8) @(posedge sys_clk_i);
    apb(1'b0, 8'h10, 33'h108);
    q_ch.push_back(12'h002);
    chw(1'b1, {EQ_SEL, 3'h0, FN_STAT}, 1'b0, 1'b1);
    wait (q_ch.size() == 0);
    $display("Read and status test done");
    q_rq.push_back(25'h1800000);
    chw(1'b1, {EQ_SEL, MOD_ZDATA, FN_BREAD}, 1'b0, 1'b1);
    chw(1'b0, 12'h800, 1'b0, 1'b1);
    chw(1'b0, 12'h000, 1'b0, 1'b1);
    wait (q_rq.size() == 0);
    repeat (10) @(posedge sys_clk_i);
    $display("Flag test done");
    chw(1'b1, {3'h4, 3'h0, FN_STAT}, 1'b0, 1'b0);
    chw(1'b1, {EQ_SEL, 3'h0, FN_STAT}, 1'b1, 1'b0);
    apb(1'b1, 8'h00, 33'h2);
    apb(1'b0, 8'h00, 33'h2);
    chw(1'b1, {EQ_SEL, 3'h0, FN_MCLR}, 1'b1, 1'b1);
    chw(1'b1, {EQ_SEL, 3'h0, 6'h3F}, 1'b0, 1'b1);
    $display("Refusal test done");
    repeat (4) @(posedge sys_clk_i);
    final_report();
  end
endmodule
